// *** core/dxop_alu.sv ***
// Result and status flag logic for the two operand groups
`timescale 1ns/1ps
module dxop_alu
  import dxop_pkg::*;
(
  input  wire dxop_alu_e   op,
  input  wire logic        byt,
  input  wire logic [15:0] s,
  input  wire logic [15:0] d,
  output logic      [15:0] res,
  output logic      [15:0] fval,
  output logic      [15:0] fmsk
);
  logic [16:0] sum;
  logic        ovf;
  logic        same;

  // Bytes arrive in the upper half, so word carry and sign work for both
  always_comb begin
    sum  = 17'h00000;
    ovf  = 1'b0;
    same = (s[15] == d[15]);
    case (op)
      AO_ADD: begin
        sum = {1'b0, s} + {1'b0, d}; // RL22
        res = sum[15:0];
        ovf = same && (res[15] != d[15]);
      end
      AO_SUB: begin
        sum = {1'b0, d} + {1'b0, ~s} + 17'h00001; // RL22
        res = sum[15:0];
        ovf = !same && (res[15] != d[15]);
      end
      AO_CMP:  res = d - s; // RL7
      AO_OR:   res = d | s; // RL8
      AO_ANDN: res = d & ~s; // RL9
      AO_XOR:  res = d ^ s; // RL23
      AO_COC:  res = d;
      AO_CZC:  res = d;
      default: res = s;
    endcase
  end

  // Flag values, then which of them the operation may touch
  always_comb begin
    fval = 16'h0000;
    if (op == AO_CMP) begin
      fval[ST_LGT] = (s[15] && !d[15]) || (same && res[15]); // RL7
      fval[ST_AGT] = (!s[15] && d[15]) || (same && res[15]);
      fval[ST_EQ]  = (s == d);
    end else begin
      fval[ST_LGT] = |res;
      fval[ST_AGT] = !res[15] && (|res);
      fval[ST_EQ]  = ~|res;
    end
    if (op == AO_COC)
      fval[ST_EQ] = ((s & ~d) == 16'h0000); // RL11
    else if (op == AO_CZC)
      fval[ST_EQ] = ((s & d) == 16'h0000); // RL12
    fval[ST_C]   = sum[16];
    fval[ST_OV]  = ovf;
    // Compare checks the source byte, the others the result byte
    fval[ST_PAR] = (op == AO_CMP) ? ^s[15:8] : ^res[15:8];
    if (op == AO_COC || op == AO_CZC)
      fmsk = FM_EQ; // RL11 RL12
    else if (op == AO_ADD || op == AO_SUB)
      fmsk = FM_ARITH | (byt ? FM_PAR : 16'h0000); // RL22
    else
      fmsk = FM_CMP | (byt ? FM_PAR : 16'h0000); // RL7 RL8 RL9
  end
endmodule : dxop_alu

// *** core/dxop_core.sv ***
// Decode and execute core for two-operand, register and trap ops
//
// Contract
// (RL1) Size bit selects byte or word operands
// (RL2) Mode field picks register, indirect, autoincrement
// (RL3) Mode 10: register zero symbolic, else indexed
// (RL4) Byte on a register uses its upper byte
// (RL5) Two-operand autoincrement steps one or two
// (RL6) Source extension word fetched before destination's
// (RL7) Compare sets flags, writes nothing
// (RL8) Set-ones ORs source into destination
// (RL9) Set-zeroes clears destination bits set in source
// (RL10) Register-destination autoincrement always steps two
// (RL11) Compare-ones sets equal flag only
// (RL12) Compare-zeros sets equal on no overlap
// (RL13) Multiply: high to register, low to next
// (RL14) Multiply on fifteen spills into next word
// (RL15) Divide overflow keeps operands, sets overflow flag
// (RL16) Divide: quotient first, remainder next register
// (RL17) Divide on fifteen spills remainder into next word
// (RL18) Trap sets flag, loads vector pair
// (RL19) Trap saves address and old context
// (RL20) No interrupt sampling right after trap
// (RL21) Two-operand field layout of the opcode
// (RL22) Add, subtract, move with their flags
// (RL23) Exclusive-or back into register, flags 0-2
`timescale 1ns/1ps
module dxop_core
  import dxop_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output dxop_mem_s        mem_o,
  input  wire logic [15:0] mem_rdata,
  input  wire logic        mem_ack,
  output logic             int_sample_en
);
  dxop_state_e state;
  logic [15:0] ir, pc, wp, st;
  logic [15:0] ext, regv, sea, dea, sval, dval, draw, d1;
  logic [15:0] nwp, npc, r0, r1;
  logic [1:0]  wcnt;
  logic        vcnt, side, illegal;
  logic        aw_got, w_got;
  logic [7:0]  wa;
  logic [31:0] wd;
  logic [3:0]  ws;
  logic        wr_fire;

  // Workspace register address
  function automatic logic [15:0] wreg(input logic [15:0] w,
                                       input logic [3:0]  r);
    return w + {11'h000, r, 1'b0};
  endfunction : wreg

  // Operand fetch: bytes are moved to the upper half
  function automatic logic [15:0] algn(input logic [15:0] w,
                                       input logic        a0,
                                       input logic        b);
    if (!b)
      return w;
    return a0 ? {w[7:0], 8'h00} : {w[15:8], 8'h00}; // RL4
  endfunction : algn

  // Bus write with byte strobes onto a 16-bit register
  function automatic logic [15:0] wmerge(input logic [15:0] o,
                                         input logic [31:0] d,
                                         input logic [3:0]  b);
    return {b[1] ? d[15:8] : o[15:8], b[0] ? d[7:0] : o[7:0]};
  endfunction : wmerge

  // Field decode of the held instruction word
  logic        fmt1, fmt2, legal, byt, is_xop, is_mpy, is_div;
  logic        use_reg, div_ovf;
  logic [1:0]  mode;
  logic [3:0]  rn, dreg;
  logic [15:0] incv, ea;
  assign fmt1    = |ir[15:14]; // RL21
  assign fmt2    = (ir[15:12] == 4'b0010) || (ir[15:11] == 5'b00111);
  assign legal   = fmt1 || fmt2;
  assign byt     = fmt1 && ir[12]; // RL1
  assign is_xop  = ir[15:10] == OPC_XOP;
  assign is_mpy  = ir[15:10] == OPC_MPY;
  assign is_div  = ir[15:10] == OPC_DIV;
  assign mode    = side ? (fmt1 ? ir[11:10] : M_REG) : ir[5:4]; // RL2
  assign rn      = side ? ir[9:6] : ir[3:0]; // RL21
  assign dreg    = ir[9:6];
  assign incv    = byt ? 16'h0001 : 16'h0002; // RL5 RL10
  // Register zero never indexes, so its read is skipped
  assign use_reg = !(mode == M_REG || (mode == M_SYM && rn == 4'h0)); // RL3
  always_comb begin
    if (mode == M_REG)
      ea = wreg(wp, rn); // RL2
    else if (mode == M_SYM)
      ea = ext + (use_reg ? regv : 16'h0000); // RL3
    else
      ea = regv;
  end

  // Arithmetic for the register-destination group
  logic [31:0] prod, quo, rem;
  assign div_ovf = sval <= dval; // RL15
  assign prod    = {16'h0000, dval} * {16'h0000, sval}; // RL13
  assign quo     = {dval, d1} / {16'h0000, sval}; // RL16
  assign rem     = {dval, d1} % {16'h0000, sval};

  // Operation select for the shared result logic
  dxop_alu_e   aop;
  logic [15:0] alu_res, fval, fmsk;
  always_comb begin
    aop = AO_MOV;
    if (fmt1) begin
      case (ir[15:13])
        OP_ADD:  aop = AO_ADD;
        OP_SUB:  aop = AO_SUB;
        OP_CMP:  aop = AO_CMP;
        OP_SOC:  aop = AO_OR;
        OP_SZC:  aop = AO_ANDN;
        default: aop = AO_MOV;
      endcase
    end else begin
      case (ir[11:10])
        2'b00:   aop = AO_COC;
        2'b01:   aop = AO_CZC;
        default: aop = AO_XOR;
      endcase
    end
  end

  dxop_alu u_alu (
    .op   (aop),
    .byt  (byt),
    .s    (sval),
    .d    (dval),
    .res  (alu_res),
    .fval (fval),
    .fmsk (fmsk)
  );

  // Number of result writes and where each one lands
  logic [2:0]  nw;
  logic [15:0] waddr, wdata;
  always_comb begin
    if (is_xop)
      nw = 3'd4;
    else if (is_mpy)
      nw = 3'd2;
    else if (is_div)
      nw = div_ovf ? 3'd0 : 3'd2; // RL15
    else if (aop == AO_CMP || aop == AO_COC || aop == AO_CZC)
      nw = 3'd0; // RL7 RL11 RL12
    else
      nw = 3'd1;
    waddr = {dea[15:1], 1'b0};
    wdata = r0;
    if (is_xop) begin
      case (wcnt)
        2'd0: begin waddr = nwp + XOP_LINK_REGISTER; wdata = sea; end // RL19
        2'd1: begin waddr = nwp + XOP_WR13; wdata = wp; end
        2'd2: begin waddr = nwp + XOP_WR14; wdata = pc; end
        default: begin waddr = nwp + XOP_SAVED_STATUS_REGISTER; wdata = st; end
      endcase
    end else if (is_mpy || is_div) begin
      // Register fifteen simply runs on into the following word
      waddr = wreg(wp, dreg) + {14'h0000, wcnt[0], 1'b0}; // RL14 RL17
      wdata = wcnt[0] ? r1 : r0;
    end
  end

  // Memory access wanted by the current state
  logic        acc_need, acc_we, step;
  logic [15:0] acc_addr, acc_wdata;
  always_comb begin
    acc_need  = 1'b0;
    acc_we    = 1'b0;
    acc_addr  = 16'h0000;
    acc_wdata = 16'h0000;
    case (state)
      S_FETCH: begin
        acc_need = 1'b1;
        acc_addr = pc;
      end
      S_EXT: begin
        acc_need = legal && mode == M_SYM; // RL6
        acc_addr = pc;
      end
      S_REG: begin
        acc_need = use_reg;
        acc_addr = wreg(wp, rn);
      end
      S_INC: begin
        acc_need  = mode == M_AINC;
        acc_we    = 1'b1;
        acc_addr  = wreg(wp, rn);
        acc_wdata = regv + incv; // RL5 RL10
      end
      S_OPR: begin
        acc_need = 1'b1;
        acc_addr = {ea[15:1], 1'b0};
      end
      S_DHI: begin
        acc_need = 1'b1;
        acc_addr = wreg(wp, dreg) + 16'h0002; // RL16
      end
      S_VEC: begin
        acc_need = 1'b1;
        acc_addr = XOP_VEC + {10'h000, dreg, 2'b00}
                 + {14'h0000, vcnt, 1'b0}; // RL18
      end
      S_WRITE: begin
        acc_need  = 1'b1;
        acc_we    = 1'b1;
        acc_addr  = waddr;
        acc_wdata = wdata;
      end
      default: ;
    endcase
  end
  assign step = acc_need ? mem_ack : 1'b1;

  // Memory request held until the acknowledge
  always_ff @(posedge aclk) begin
    if (!aresetn)
      mem_o <= '0;
    else if (mem_o.req) begin
      if (mem_ack)
        mem_o.req <= 1'b0;
    end else if (acc_need)
      mem_o <= '{req: 1'b1, we: acc_we, addr: acc_addr, wdata: acc_wdata};
  end

  // Instruction sequencer; bus writes to PC, WP and ST land only while idle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= S_IDLE;
      ir <= 16'h0000; pc <= PC_RST; wp <= WP_RST; st <= ST_RST;
      ext <= 16'h0000; regv <= 16'h0000; sea <= 16'h0000;
      dea <= 16'h0000; sval <= 16'h0000; dval <= 16'h0000;
      draw <= 16'h0000; d1 <= 16'h0000; nwp <= 16'h0000;
      npc <= 16'h0000; r0 <= 16'h0000; r1 <= 16'h0000;
      wcnt <= 2'd0; vcnt <= 1'b0; side <= 1'b0; illegal <= 1'b0;
      int_sample_en <= 1'b0;
    end else begin
      case (state)
        S_IDLE: if (wr_fire) begin
          if (wa == DX_CTRL) begin
            if (wd[CTRL_GO]) begin
              illegal <= 1'b0;
              int_sample_en <= 1'b0;
              state <= S_FETCH;
            end
          end else if (wa == DX_PC)
            pc <= wmerge(pc, wd, ws);
          else if (wa == DX_WP)
            wp <= wmerge(wp, wd, ws);
          else if (wa == DX_ST)
            st <= wmerge(st, wd, ws) & ST_WMASK;
        end
        S_FETCH: if (step) begin
          ir <= mem_rdata;
          pc <= pc + 16'h0002;
          side <= 1'b0;
          state <= S_EXT;
        end
        // Group excluded here: flagged and abandoned
        S_EXT: if (!legal) begin
          illegal <= 1'b1;
          state <= S_DONE;
        end else if (step) begin
          if (acc_need) begin
            ext <= mem_rdata; // RL6
            pc <= pc + 16'h0002;
          end
          state <= S_REG;
        end
        S_REG: if (step) begin
          if (acc_need)
            regv <= mem_rdata;
          state <= S_INC;
        end
        S_INC: if (step) begin
          if (!side && is_xop) begin
            sea <= ea;
            vcnt <= 1'b0;
            state <= S_VEC;
          end else
            state <= S_OPR;
        end
        S_OPR: if (step) begin
          if (!side) begin
            sval <= algn(mem_rdata, ea[0], byt); // RL1
            sea <= ea;
            side <= 1'b1;
            state <= S_EXT;
          end else begin
            dval <= algn(mem_rdata, ea[0], byt);
            draw <= mem_rdata;
            dea <= ea;
            state <= is_div ? S_DHI : S_EXEC;
          end
        end
        S_DHI: if (step) begin
          d1 <= mem_rdata;
          state <= S_EXEC;
        end
        S_VEC: if (step) begin
          if (!vcnt) begin
            nwp <= mem_rdata; // RL18
            vcnt <= 1'b1;
          end else begin
            npc <= mem_rdata;
            wcnt <= 2'd0;
            state <= S_WRITE;
          end
        end
        S_EXEC: begin
          if (is_mpy) begin
            r0 <= prod[31:16]; // RL13
            r1 <= prod[15:0];
          end else if (is_div) begin
            st[ST_OV] <= div_ovf; // RL15
            r0 <= quo[15:0]; // RL16
            r1 <= rem[15:0];
          end else begin
            st <= (st & ~fmsk) | (fval & fmsk); // RL22 RL23
            // Byte result keeps the other half of the word
            if (byt)
              r0 <= dea[0] ? {draw[15:8], alu_res[15:8]}
                           : {alu_res[15:8], draw[7:0]}; // RL4
            else
              r0 <= alu_res;
          end
          wcnt <= 2'd0;
          state <= (nw == 3'd0) ? S_DONE : S_WRITE;
        end
        S_WRITE: if (step) begin
          if ({1'b0, wcnt} == nw - 3'd1) begin
            if (is_xop) begin
              wp <= nwp; // RL18
              pc <= npc;
              st[ST_X] <= 1'b1;
            end
            state <= S_DONE;
          end else
            wcnt <= wcnt + 2'd1;
        end
        S_DONE: begin
          // Handler's first instruction must run unhindered
          int_sample_en <= !is_xop; // RL20
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // Write address and data channels, taken in either order
  assign wr_fire = aw_got && w_got && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0; w_got <= 1'b0;
      s_axi_awready <= 1'b1; s_axi_wready <= 1'b1;
      wa <= 8'h00; wd <= 32'h00000000; ws <= 4'h0;
      s_axi_bvalid <= 1'b0; s_axi_bresp <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got <= 1'b1;
        wa <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got <= 1'b1;
        wd <= s_axi_wdata;
        ws <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (wa == DX_CTRL || wa == DX_STAT || wa == DX_PC
            || wa == DX_WP || wa == DX_ST)
          s_axi_bresp <= 2'b00;
        else
          s_axi_bresp <= 2'b10;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Read channel; data captured at the address handshake
  logic [31:0] rmux;
  logic        rerr;
  always_comb begin
    rmux = 32'h00000000;
    rerr = 1'b0;
    if (s_axi_araddr == DX_CTRL)
      rmux = 32'h00000000;
    else if (s_axi_araddr == DX_STAT)
      rmux = {29'h0, int_sample_en, illegal, state != S_IDLE};
    else if (s_axi_araddr == DX_PC)
      rmux = {16'h0000, pc};
    else if (s_axi_araddr == DX_WP)
      rmux = {16'h0000, wp};
    else if (s_axi_araddr == DX_ST)
      rmux = {16'h0000, st};
    else
      rerr = 1'b1;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1; s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000; s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rmux;
      s_axi_rresp <= rerr ? 2'b10 : 2'b00;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Checks on the sequencer
  default clocking dx_cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence xop_end;
    state == S_WRITE && mem_ack && is_xop && wcnt == 2'd3;
  endsequence
  chk_xop_trap: assert property ( // RL18
    xop_end |=> st[ST_X] && wp == $past(nwp) && pc == $past(npc))
    else $error("trap context not loaded");
  chk_int_hold: assert property ( // RL20
    xop_end ##1 state == S_DONE |=> !int_sample_en)
    else $error("interrupt sampling allowed after trap");
  chk_xop_save: assert property ( // RL19
    state == S_WRITE && is_xop && mem_o.req && wcnt == 2'd3
    |-> mem_o.addr == nwp + XOP_SAVED_STATUS_REGISTER && mem_o.wdata == st)
    else $error("old status not saved in new register fifteen");
  chk_ainc_step: assert property ( // RL5
    state == S_INC && mem_o.req |-> mem_o.we
    && mem_o.wdata == regv + (byt ? 16'h0001 : 16'h0002))
    else $error("autoincrement step wrong");
  chk_cmp_nowr: assert property ( // RL7
    state == S_EXEC && aop == AO_CMP |=> state == S_DONE)
    else $error("compare wrote a result");
  chk_div_ovf: assert property ( // RL15
    state == S_EXEC && is_div && div_ovf |=> st[ST_OV] && state == S_DONE)
    else $error("divide overflow not flagged");
  chk_mpy_flags: assert property ( // RL13
    state == S_EXEC && is_mpy |=> $stable(st))
    else $error("multiply changed status");
  chk_sym_noreg: assert property ( // RL3
    state == S_REG && mode == M_SYM && rn == 4'h0 |-> !mem_o.req)
    else $error("register zero read as index");
  chk_req_hold: assert property (
    mem_o.req && !mem_ack |=> mem_o.req && $stable(mem_o.addr))
    else $error("memory request dropped before acknowledge");
endmodule : dxop_core

// *** core/dxop_pkg.sv ***
// Shared constants and types for the decode and execute core
package dxop_pkg;
  // Register byte offsets on the control bus
  localparam logic [7:0] DX_CTRL = 8'h00;
  localparam logic [7:0] DX_STAT = 8'h04;
  localparam logic [7:0] DX_PC   = 8'h08;
  localparam logic [7:0] DX_WP   = 8'h0c;
  localparam logic [7:0] DX_ST   = 8'h10;
  localparam int         CTRL_GO = 0;
  // Values after reset
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [15:0] WP_RST = 16'h0000;
  localparam logic [15:0] ST_RST = 16'h0000;
  // Unused status bits read as zero
  localparam logic [15:0] ST_WMASK = 16'hfe0f;
  // Status bit positions, leftmost bit is bit 15 here
  localparam int ST_LGT = 15;
  localparam int ST_AGT = 14;
  localparam int ST_EQ  = 13;
  localparam int ST_C   = 12;
  localparam int ST_OV  = 11;
  localparam int ST_PAR = 10;
  localparam int ST_X   = 9;
  localparam logic [15:0] FM_CMP   = 16'he000;
  localparam logic [15:0] FM_ARITH = 16'hf800;
  localparam logic [15:0] FM_EQ    = 16'h2000;
  localparam logic [15:0] FM_PAR   = 16'h0400;
  // Addressing modes
  localparam logic [1:0] M_REG  = 2'b00;
  localparam logic [1:0] M_IND  = 2'b01;
  localparam logic [1:0] M_SYM  = 2'b10;
  localparam logic [1:0] M_AINC = 2'b11;
  // Two-operand opcodes
  localparam logic [2:0] OP_SZC = 3'b010;
  localparam logic [2:0] OP_SUB = 3'b011;
  localparam logic [2:0] OP_CMP = 3'b100;
  localparam logic [2:0] OP_ADD = 3'b101;
  localparam logic [2:0] OP_MOV = 3'b110;
  localparam logic [2:0] OP_SOC = 3'b111;
  // Register-destination opcodes
  localparam logic [5:0] OPC_XOP = 6'b001011;
  localparam logic [5:0] OPC_MPY = 6'b001110;
  localparam logic [5:0] OPC_DIV = 6'b001111;
  // Trap vector table and saved-context slots
  localparam logic [15:0] XOP_VEC  = 16'h0040;
  localparam logic [15:0] XOP_LINK_REGISTER = 16'h0016;
  localparam logic [15:0] XOP_WR13 = 16'h001a;
  localparam logic [15:0] XOP_WR14 = 16'h001c;
  localparam logic [15:0] XOP_SAVED_STATUS_REGISTER = 16'h001e;

  typedef enum logic [3:0] {
    AO_ADD, AO_SUB, AO_CMP, AO_OR, AO_ANDN, AO_MOV, AO_COC, AO_CZC, AO_XOR
  } dxop_alu_e;

  typedef enum logic [10:0] {
    S_IDLE  = 11'h001,
    S_FETCH = 11'h002,
    S_EXT   = 11'h004,
    S_REG   = 11'h008,
    S_INC   = 11'h010,
    S_OPR   = 11'h020,
    S_DHI   = 11'h040,
    S_VEC   = 11'h080,
    S_EXEC  = 11'h100,
    S_WRITE = 11'h200,
    S_DONE  = 11'h400
  } dxop_state_e;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } dxop_mem_s;
endpackage : dxop_pkg

// *** tb/dxop_mem_model.sv ***
// Behavioural word memory behind the core's memory port
`timescale 1ns/1ps
module dxop_mem_model
  import dxop_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire dxop_mem_s  mem_i,
  input  wire logic [3:0] lat,
  output logic [15:0]     rdata,
  output logic            ack
);
  logic [15:0] mem [0:32767];
  logic [3:0]  cnt;
  logic [15:0] q = 16'h0;
  // One ack pulse per request after lat idle cycles, so slow answers
  // make the core hold its request
  always @(posedge aclk) begin
    if (!aresetn || !mem_i.req || ack) begin
      cnt <= 4'h0;
      ack <= 1'b0;
    end else if (cnt == lat) begin
      ack <= 1'b1;
      q   <= mem[mem_i.addr[15:1]];
      if (mem_i.we) mem[mem_i.addr[15:1]] <= mem_i.wdata;
    end else cnt <= cnt + 4'h1;
  end
  // Inverse outside ack, so a stale sample cannot pass
  assign rdata = ack ? q : ~q;
endmodule : dxop_mem_model

// *** tb/tb_top.sv ***
// Self-checking bench: control over AXI4-Lite, memory model behind
`timescale 1ns/1ps
module tb_top
  import dxop_pkg::*;
;
  logic        aclk = 1'b0, aresetn = 1'b0, aw_v = 1'b0, w_v = 1'b0;
  logic        b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
  logic        aw_r, w_r, b_v, ar_r, r_v, m_ack, int_en;
  logic [7:0]  aw_a = 8'h0, ar_a = 8'h0;
  logic [31:0] w_d = 32'h0, r_d;
  logic [1:0]  b_s, r_s, rs;
  logic [15:0] m_rd, v;
  logic [3:0]  lat = 4'h0;
  dxop_mem_s   m_o;
  int          n_errors = 0, checks_done = 0, cyc = 0;

  dxop_core dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw_a),
    .s_axi_awvalid(aw_v), .s_axi_awready(aw_r), .s_axi_wdata(w_d),
    .s_axi_wstrb(4'h3), .s_axi_wvalid(w_v), .s_axi_wready(w_r),
    .s_axi_bresp(b_s), .s_axi_bvalid(b_v), .s_axi_bready(b_r),
    .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r),
    .s_axi_rdata(r_d), .s_axi_rresp(r_s), .s_axi_rvalid(r_v),
    .s_axi_rready(r_r), .mem_o(m_o), .mem_rdata(m_rd), .mem_ack(m_ack),
    .int_sample_en(int_en));
  dxop_mem_model mm (.aclk(aclk), .aresetn(aresetn), .mem_i(m_o),
    .lat(lat), .rdata(m_rd), .ack(m_ack));

  always #50 aclk = ~aclk;
  // Watchdog, a stuck handshake still reaches the verdict
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_errors = n_errors + 1;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [15:0] got, exp);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Each channel released at its own handshake edge
  task automatic axw(input logic [7:0] a, input logic [15:0] d);
    aw_a <= a;
    w_d  <= {16'h0, d};
    aw_v <= 1'b1;
    w_v  <= 1'b1;
    b_r  <= 1'b1;
    do begin
      @(posedge aclk);
      if (aw_r) aw_v <= 1'b0;
      if (w_r) w_v <= 1'b0;
    end while (!b_v);
    rs = b_s;
  endtask : axw

  task automatic axr(input logic [7:0] a);
    ar_a <= a;
    ar_v <= 1'b1;
    r_r  <= 1'b1;
    do begin
      @(posedge aclk);
      if (ar_r) ar_v <= 1'b0;
    end while (!r_v);
    v  = r_d[15:0];
    rs = r_s;
  endtask : axr

  // Workspace at 0x0200; register n is the word at 0x0200 + 2n
  function automatic logic [15:0] r(input logic [15:0] n);
    return 16'h0200 + (n << 1);
  endfunction : r
  task automatic wr(input logic [15:0] a, d);
    mm.mem[a[14:0] >> 1] = d;
  endtask : wr
  function automatic logic [15:0] rd(input logic [15:0] a);
    return mm.mem[a[14:0] >> 1];
  endfunction : rd

  // Runs one instruction at 0x0100 and checks the resulting status
  task automatic ex(input logic [15:0] i, st0, st1);
    wr(16'h0100, i);
    lat <= {2'b00, lat[1:0] + 2'b01};
    axw(DX_WP, 16'h0200);
    axw(DX_ST, st0);
    axw(DX_PC, 16'h0100);
    axw(DX_CTRL, 16'h0001);
    do axr(DX_STAT); while (v[0] !== 1'b0);
    chk("int_en", {15'h0, int_en}, {15'h0, i[15:10] != OPC_XOP});
    axr(DX_ST);
    chk("status", v, st1);
    $display("test %h done", i);
  endtask : ex

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axr(DX_WP);
    chk("wp_rst", v, WP_RST);
    axw(DX_ST, 16'hffff);
    axr(DX_ST);
    chk("st_mask", v, ST_WMASK);
    axr(8'h40);
    chk("unmapped_rd", {rs, v[13:0]}, 16'h8000);
    axw(8'h44, 16'h1234);
    chk("unmapped_wr", {14'h0, rs}, 16'h0002);
    $display("test bus done");
    wr(r(1), 16'h7000);
    wr(r(2), 16'h1000);
    ex(16'ha081, 16'h0000, 16'h8800);
    chk("add", rd(r(2)), 16'h8000);
    ex(16'h6081, 16'h0000, 16'hd800);
    chk("sub", rd(r(2)), 16'h1000);
    wr(r(3), 16'h0301);
    wr(16'h0300, 16'h12f7);
    wr(r(4), 16'haa55);
    ex(16'hd133, 16'h0000, 16'h8400);
    chk("movb_dst", rd(r(4)), 16'hf755);
    chk("movb_inc", rd(r(3)), 16'h0302);
    wr(r(6), 16'h0500);
    wr(16'h0102, 16'h0400);
    wr(16'h0104, 16'h0010);
    wr(16'h0400, 16'hff00);
    wr(16'h0510, 16'h1234);
    ex(16'h49a0, 16'h0000, 16'hc000);
    chk("szc", rd(16'h0510), 16'h0034);
    wr(r(7), 16'h8100);
    wr(r(8), 16'h0600);
    wr(16'h0600, 16'h0233);
    ex(16'hf607, 16'h0000, 16'h8400);
    chk("socb", rd(16'h0600), 16'h8333);
    wr(r(9), 16'h0003);
    wr(r(10), 16'h0002);
    ex(16'h8289, 16'h0000, 16'hc000);
    chk("cmp_dst", rd(r(10)), 16'h0002);
    wr(r(11), 16'h0700);
    wr(16'h0700, 16'h00f0);
    wr(r(12), 16'h0ff0);
    ex(16'h233b, 16'hc000, 16'he000);
    chk("coc_inc", rd(r(11)), 16'h0702);
    wr(r(13), 16'hf000);
    ex(16'h260d, 16'h0000, 16'h2000);
    wr(r(1), 16'h7000);
    wr(r(2), 16'h8000);
    ex(16'h2881, 16'h0000, 16'h8000);
    chk("xor", rd(r(2)), 16'hf000);
    wr(r(1), 16'hffff);
    wr(r(15), 16'hffff);
    ex(16'h3bc1, 16'h2000, 16'h2000);
    chk("mpy_hi", rd(r(15)), 16'hfffe);
    chk("mpy_lo", rd(r(16)), 16'h0001);
    wr(r(1), 16'h0010);
    wr(r(4), 16'h0001);
    wr(r(5), 16'h0005);
    ex(16'h3d01, 16'h0800, 16'h0000);
    chk("div_q", rd(r(4)), 16'h1000);
    chk("div_r", rd(r(5)), 16'h0005);
    wr(r(4), 16'h0010);
    ex(16'h3d01, 16'h0000, 16'h0800);
    chk("div_ovf", rd(r(4)), 16'h0010);
    wr(r(1), 16'h0100);
    wr(r(15), 16'h0000);
    wr(r(16), 16'h1234);
    ex(16'h3fc1, 16'h0000, 16'h0000);
    chk("div15_q", rd(r(15)), 16'h0012);
    chk("div15_r", rd(r(16)), 16'h0034);
    ex(16'h3000, 16'h0000, 16'h0000);
    axr(DX_STAT);
    chk("illegal", v, 16'h0006);
    wr(r(3), 16'h0800);
    wr(16'h0048, 16'h0a00);
    wr(16'h004a, 16'h0c00);
    ex(16'h2c93, 16'h0003, 16'h0203);
    chk("xop_sa", rd(16'h0a16), 16'h0800);
    chk("xop_wp", rd(16'h0a1a), 16'h0200);
    chk("xop_pc", rd(16'h0a1c), 16'h0102);
    chk("xop_st", rd(16'h0a1e), 16'h0003);
    axr(DX_PC);
    chk("xop_new_pc", v, 16'h0c00);
    give_verdict();
  end
endmodule : tb_top
